// ===== core/opd_dec.sv
// top: classifies opcodes 0x40-0x7f and 0xc0-0xff, one cycle latency
`timescale 1ns/1ps
module opd_dec
   import opd_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // opcode from fetch
   input wire logic i_op_valid,
   input wire logic [7:0] i_opcode,
   // decoded result to execution control
   output logic o_valid,
   output logic o_known,
   output logic [7:0] o_opcode,
   output opd_class_t o_op_class,
   output opd_opnd_t o_opnd,
   output logic [2:0] o_reg_num,
   output logic o_ri_sel,
   output logic [2:0] o_page
);

   opd_fld_if fld ();
   opd_class_t cls_d;
   opd_opnd_t opnd_d;
   logic known_d;

   // low nibble 4..f of the alu, move and exchange groups picks the source
   function automatic opd_opnd_t alu_src(input logic [3:0] lo);
      opd_opnd_t r;
      r = OPD_O_NONE;
      case (lo)
         4'h4: r = OPD_O_IMM;
         4'h5: r = OPD_O_DIR;
         4'h6, 4'h7: r = OPD_O_IND;
         default: r = lo[3] ? OPD_O_REG : OPD_O_NONE;
      endcase
      return r;
   endfunction

   assign fld.opcode = i_opcode;

   opd_field_xtr u_fld (
      .fld (fld)
   );

   // both covered ranges are exactly the opcodes with bit 6 set
   assign known_d = i_opcode[OPD_RANGE_BIT];

   always_comb begin
      cls_d = OPD_C_NONE;
      opnd_d = OPD_O_NONE;
      if (known_d) begin
         casez (i_opcode)
            8'h40: begin
               cls_d = OPD_C_JC;
               opnd_d = OPD_O_REL;
            end
            8'h50: begin
               cls_d = OPD_C_JNC;
               opnd_d = OPD_O_REL;
            end
            8'h60: begin
               cls_d = OPD_C_JZ;
               opnd_d = OPD_O_REL;
            end
            8'h70: begin
               cls_d = OPD_C_JNZ;
               opnd_d = OPD_O_REL;
            end
            8'b???0_0001: begin
               cls_d = OPD_C_AJMP;
               opnd_d = OPD_O_ADDR11;
            end
            8'b???1_0001: begin
               cls_d = OPD_C_ACALL;
               opnd_d = OPD_O_ADDR11;
            end
            8'hc0: begin
               cls_d = OPD_C_PUSH;
               opnd_d = OPD_O_DIR;
            end
            8'hd0: begin
               cls_d = OPD_C_POP;
               opnd_d = OPD_O_DIR;
            end
            8'h42: begin
               cls_d = OPD_C_OR_DA;
               opnd_d = OPD_O_DIR;
            end
            8'h43: begin
               cls_d = OPD_C_OR_DI;
               opnd_d = OPD_O_DIR;
            end
            8'h52: begin
               cls_d = OPD_C_AND_DA;
               opnd_d = OPD_O_DIR;
            end
            8'h53: begin
               cls_d = OPD_C_AND_DI;
               opnd_d = OPD_O_DIR;
            end
            8'h62: begin
               cls_d = OPD_C_XOR_DA;
               opnd_d = OPD_O_DIR;
            end
            8'h63: begin
               cls_d = OPD_C_XOR_DI;
               opnd_d = OPD_O_DIR;
            end
            8'h72: begin
               cls_d = OPD_C_OR_CBIT;
               opnd_d = OPD_O_BIT;
            end
            8'h73: begin
               cls_d = OPD_C_JMP_IND;
               opnd_d = OPD_O_DPTR;
            end
            8'h74: begin
               cls_d = OPD_C_LOAD_IMM;
               opnd_d = OPD_O_ACC;
            end
            8'hc2: begin
               cls_d = OPD_C_CLR_BIT;
               opnd_d = OPD_O_BIT;
            end
            8'hc3: begin
               cls_d = OPD_C_CLR_C;
               opnd_d = OPD_O_CARRY;
            end
            8'hd2: begin
               cls_d = OPD_C_SET_BIT;
               opnd_d = OPD_O_BIT;
            end
            8'hd3: begin
               cls_d = OPD_C_SET_C;
               opnd_d = OPD_O_CARRY;
            end
            8'hc4: begin
               cls_d = OPD_C_SWAP;
               opnd_d = OPD_O_ACC;
            end
            8'he4: begin
               cls_d = OPD_C_CLR_A;
               opnd_d = OPD_O_ACC;
            end
            8'hf4: begin
               cls_d = OPD_C_CPL_A;
               opnd_d = OPD_O_ACC;
            end
            8'hd4: begin
               cls_d = OPD_C_DEC_ADJ;
               opnd_d = OPD_O_ACC;
            end
            8'hd5: begin
               cls_d = OPD_C_DJNZ;
               opnd_d = OPD_O_DIR;
            end
            8'b1101_1???: begin
               cls_d = OPD_C_DJNZ;
               opnd_d = OPD_O_REG;
            end
            8'b1101_011?: begin
               cls_d = OPD_C_XCHD;
               opnd_d = OPD_O_IND;
            end
            8'he0: begin
               cls_d = OPD_C_XRD;
               opnd_d = OPD_O_DPTR;
            end
            8'hf0: begin
               cls_d = OPD_C_XWR;
               opnd_d = OPD_O_DPTR;
            end
            8'b1110_001?: begin
               cls_d = OPD_C_XRD;
               opnd_d = OPD_O_IND;
            end
            8'b1111_001?: begin
               cls_d = OPD_C_XWR;
               opnd_d = OPD_O_IND;
            end
            default: begin
               // remaining slots are the source-selected groups
               opnd_d = alu_src(i_opcode[3:0]);
               case (i_opcode[7:4])
                  4'h4: cls_d = OPD_C_OR_A;
                  4'h5: cls_d = OPD_C_AND_A;
                  4'h6: cls_d = OPD_C_XOR_A;
                  4'h7: cls_d = OPD_C_LOAD_IMM;
                  4'hc: cls_d = OPD_C_XCH;
                  4'he: cls_d = OPD_C_TO_A;
                  4'hf: cls_d = OPD_C_FROM_A;
                  default: cls_d = OPD_C_NONE;
               endcase
               // load-immediate low nibble 4 names the accumulator as destination
               if (i_opcode[7:4] == 4'h7 && opnd_d == OPD_O_IMM) begin
                  opnd_d = OPD_O_ACC;
               end
               if (cls_d == OPD_C_NONE) begin
                  opnd_d = OPD_O_NONE;
               end
            end
         endcase
      end
   end

   // handshake pulse follows the request by one cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_op_valid;
      end
   end

   // result registers only load on a request, so they hold between opcodes
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_known <= 1'b0;
         o_opcode <= OPD_OPCODE_RST;
         o_op_class <= OPD_C_NONE;
         o_opnd <= OPD_O_NONE;
      end else if (i_op_valid) begin
         o_known <= known_d;
         o_opcode <= i_opcode;
         o_op_class <= cls_d;
         o_opnd <= opnd_d;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_num <= '0;
         o_ri_sel <= 1'b0;
         o_page <= '0;
      end else if (i_op_valid) begin
         o_reg_num <= fld.reg_num;
         o_ri_sel <= fld.ri_sel;
         o_page <= fld.page;
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   chk_valid_pulse: assert property (
      i_op_valid |=> o_valid && o_opcode == $past(i_opcode))
      else $error("decode result not presented one cycle after request");

   chk_carry_jumps: assert property (
      o_valid && o_opcode inside {8'h40, 8'h50}
      |-> o_opnd == OPD_O_REL
          && o_op_class == (o_opcode[4] ? OPD_C_JNC : OPD_C_JC))
      else $error("carry jump misclassified");

   chk_stack_ops: assert property (
      i_op_valid && i_opcode inside {8'hc0, 8'hd0}
      |=> o_opnd == OPD_O_DIR
          && o_op_class == (o_opcode[4] ? OPD_C_POP : OPD_C_PUSH))
      else $error("push or pop misclassified");

   chk_abs_jump_page: assert property (
      i_op_valid && i_opcode inside {8'h41, 8'h61, 8'hc1, 8'he1}
      |=> o_op_class == OPD_C_AJMP && o_page == $past(i_opcode[7:5]))
      else $error("absolute jump or its page wrong");

   chk_abs_call: assert property (
      i_op_valid && i_opcode inside {8'h51, 8'h71, 8'hd1, 8'hf1}
      |=> o_op_class == OPD_C_ACALL && o_opnd == OPD_O_ADDR11)
      else $error("absolute call misclassified");

   chk_zero_jumps: assert property (
      o_valid && o_opcode inside {8'h60, 8'h70}
      |-> o_op_class == (o_opcode[4] ? OPD_C_JNZ : OPD_C_JZ))
      else $error("accumulator-zero jump misclassified");

   chk_ext_data: assert property (
      o_valid && o_opcode inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}
      |-> o_op_class == (o_opcode[4] ? OPD_C_XWR : OPD_C_XRD)
          && o_opnd == (o_opcode[1] ? OPD_O_IND : OPD_O_DPTR))
      else $error("external data transfer misclassified");

   chk_or_direct: assert property (
      i_op_valid && i_opcode inside {8'h42, 8'h43}
      |=> o_op_class == (o_opcode[0] ? OPD_C_OR_DI : OPD_C_OR_DA))
      else $error("or into direct byte misclassified");

   chk_or_acc: assert property (
      o_valid && o_opcode[7:4] == 4'h4 && o_opcode[3:0] >= 4'h4
      |-> o_op_class == OPD_C_OR_A && o_opnd != OPD_O_NONE)
      else $error("or into accumulator misclassified");

   chk_and_direct: assert property (
      i_op_valid && i_opcode inside {8'h52, 8'h53}
      |=> o_op_class == (o_opcode[0] ? OPD_C_AND_DI : OPD_C_AND_DA))
      else $error("and into direct byte misclassified");

   chk_and_acc: assert property (
      o_valid && o_opcode inside {[8'h58:8'h5f]}
      |-> o_op_class == OPD_C_AND_A && o_opnd == OPD_O_REG
          && o_reg_num == o_opcode[2:0])
      else $error("and from register misclassified");

   chk_xor_direct: assert property (
      o_valid && o_opcode inside {8'h62, 8'h63}
      |-> o_op_class == (o_opcode[0] ? OPD_C_XOR_DI : OPD_C_XOR_DA))
      else $error("xor into direct byte misclassified");

   chk_xor_acc_src: assert property (
      i_op_valid && i_opcode inside {[8'h64:8'h67]}
      |=> o_op_class == OPD_C_XOR_A
          && o_opnd == (o_opcode[1] ? OPD_O_IND : (o_opcode[0] ? OPD_O_DIR : OPD_O_IMM)))
      else $error("xor source mode wrong");

   chk_ind_jump: assert property (
      i_op_valid && i_opcode == 8'h73 |=> o_op_class == OPD_C_JMP_IND)
      else $error("indirect jump misclassified");

   chk_load_imm: assert property (
      o_valid && o_opcode[7:3] == 5'b01111 |-> o_op_class == OPD_C_LOAD_IMM
          && o_opnd == OPD_O_REG && o_reg_num == o_opcode[2:0])
      else $error("immediate load into register wrong");

   chk_load_imm_acc: assert property (
      i_op_valid && i_opcode == 8'h74 ##1 !i_op_valid
      |=> o_opnd == OPD_O_ACC && o_op_class == OPD_C_LOAD_IMM)
      else $error("immediate load into accumulator not held");

   chk_bit_ops: assert property (
      o_valid && o_opcode inside {8'hc2, 8'hc3, 8'hd2, 8'hd3}
      |-> o_op_class == (o_opcode[4] ? (o_opcode[0] ? OPD_C_SET_C : OPD_C_SET_BIT)
                                     : (o_opcode[0] ? OPD_C_CLR_C : OPD_C_CLR_BIT)))
      else $error("bit set or clear misclassified");

   chk_acc_unary: assert property (
      i_op_valid && i_opcode inside {8'hc4, 8'he4, 8'hf4}
      |=> o_opnd == OPD_O_ACC && o_op_class inside {OPD_C_SWAP, OPD_C_CLR_A, OPD_C_CPL_A})
      else $error("accumulator unary op misclassified");

   chk_exchange: assert property (
      o_valid && o_opcode inside {[8'hc6:8'hc7]}
      |-> o_op_class == OPD_C_XCH && o_ri_sel == o_opcode[0])
      else $error("exchange through pointer wrong");

   chk_nibble_xchg: assert property (
      i_op_valid && i_opcode inside {8'hd6, 8'hd7}
      |=> o_op_class == OPD_C_XCHD && o_ri_sel == $past(i_opcode[0]))
      else $error("nibble exchange misclassified");

   chk_dec_adjust: assert property (
      o_valid && o_opcode == 8'hd4 |-> o_op_class == OPD_C_DEC_ADJ)
      else $error("decimal adjust misclassified");

   chk_djnz: assert property (
      o_valid && o_opcode inside {8'hd5, [8'hd8:8'hdf]}
      |-> o_op_class == OPD_C_DJNZ && o_opnd == (o_opcode[3] ? OPD_O_REG : OPD_O_DIR))
      else $error("decrement-and-jump misclassified");

   chk_load_acc: assert property (
      o_valid && o_opcode inside {[8'he5:8'hef]} && o_opcode != 8'h00
      |-> o_op_class == OPD_C_TO_A)
      else $error("load into accumulator misclassified");

   chk_store_acc: assert property (
      o_valid && o_opcode inside {[8'hf5:8'hff]} |-> o_op_class == OPD_C_FROM_A)
      else $error("store of accumulator misclassified");

   chk_out_of_range: assert property (
      o_valid && !o_opcode[6] |-> !o_known && o_op_class == OPD_C_NONE)
      else $error("opcode outside covered ranges was classified");

   cov_call_page: cover property (o_valid && o_op_class == OPD_C_ACALL && o_page == 3'h7);
   cov_ext_write: cover property (o_valid && o_op_class == OPD_C_XWR ##1 o_valid);
   cov_djnz_reg: cover property (o_valid && o_op_class == OPD_C_DJNZ && o_reg_num == 3'h7);
   cov_gap: cover property (!o_valid ##1 o_valid && !o_known);

endmodule // opd_dec

// ===== core/opd_pkg.sv
// package: constants and types of the upper-range opcode decoder
// Functional notes
// - 0x40 is jump-if-carry, 0x50 jump-if-no-carry, both relative.
// - 0xC0 pushes a direct byte, 0xD0 pops into a direct byte.
// - 0x41/0x61/0xC1/0xE1 are 11-bit jumps; top opcode bits give page.
// - 0x51/0x71/0xD1/0xF1 are 11-bit subroutine calls.
// - 0x60 jumps if accumulator zero, 0x70 if nonzero.
// - 0xE0/0xF0 external read/write by pointer; 0xE2-3/0xF2-3 by R0/R1.
// - 0x42 ORs accumulator into direct byte, 0x43 ORs immediate there.
// - 0x44-0x4F OR into accumulator from imm, direct, @Ri, or Rn.
// - 0x52 ANDs accumulator into direct byte, 0x53 ANDs immediate there.
// - 0x54-0x5F AND into accumulator from imm, direct, @Ri, or Rn.
// - 0x62/0x63 XOR into direct byte from accumulator or immediate.
// - 0x64-0x6F XOR into accumulator from imm, direct, @Ri, or Rn.
// - 0x73 jumps to accumulator plus data pointer.
// - 0x74-0x7F load immediate into acc, direct, @Ri or Rn.
// - 0xC2/0xC3 clear bit/carry, 0xD2/0xD3 set them, 0x72 ORs bit to carry.
// - 0xC4 swaps nibbles, 0xE4 clears, 0xF4 complements accumulator.
// - 0xC5-0xCF exchange accumulator with direct, @Ri or Rn.
// - 0xD6/0xD7 exchange low nibbles of accumulator and @R0/@R1.
// - 0xD4 is decimal adjust of the accumulator.
// - 0xD5 decrement direct and jump if nonzero; 0xD8-0xDF same on Rn.
// - 0xE5-0xEF load accumulator from direct, @Ri or Rn.
// - 0xF5-0xFF store accumulator to direct, @Ri or Rn.
package opd_pkg;
   localparam int OPD_OP_W = 8;
   localparam int OPD_REG_LSB = 0;
   localparam int OPD_REG_W = 3;
   localparam int OPD_RI_BIT = 0;
   localparam int OPD_PAGE_LSB = 5;
   localparam int OPD_PAGE_W = 3;
   localparam int OPD_RANGE_BIT = 6;
   localparam int OPD_LAT_CYC = 1;
   localparam logic [7:0] OPD_OPCODE_RST = 8'h00;

   typedef enum logic [5:0] {
      OPD_C_NONE, OPD_C_JC, OPD_C_JNC, OPD_C_JZ, OPD_C_JNZ,
      OPD_C_AJMP, OPD_C_ACALL, OPD_C_PUSH, OPD_C_POP,
      OPD_C_OR_DA, OPD_C_OR_DI, OPD_C_OR_A,
      OPD_C_AND_DA, OPD_C_AND_DI, OPD_C_AND_A,
      OPD_C_XOR_DA, OPD_C_XOR_DI, OPD_C_XOR_A,
      OPD_C_JMP_IND, OPD_C_LOAD_IMM, OPD_C_OR_CBIT,
      OPD_C_CLR_BIT, OPD_C_CLR_C, OPD_C_SET_BIT, OPD_C_SET_C,
      OPD_C_SWAP, OPD_C_CLR_A, OPD_C_CPL_A, OPD_C_DEC_ADJ,
      OPD_C_XCH, OPD_C_XCHD, OPD_C_DJNZ,
      OPD_C_XRD, OPD_C_XWR, OPD_C_TO_A, OPD_C_FROM_A
   } opd_class_t;

   // operand other than the accumulator (or the accumulator itself)
   typedef enum logic [3:0] {
      OPD_O_NONE, OPD_O_IMM, OPD_O_DIR, OPD_O_IND, OPD_O_REG,
      OPD_O_REL, OPD_O_ADDR11, OPD_O_DPTR, OPD_O_BIT, OPD_O_CARRY, OPD_O_ACC
   } opd_opnd_t;
endpackage

// ===== core/opd_fld_if.sv
// interface: opcode in, operand fields out
`timescale 1ns/1ps
interface opd_fld_if;
   import opd_pkg::*;
   logic [OPD_OP_W-1:0] opcode;
   logic [OPD_REG_W-1:0] reg_num;
   logic ri_sel;
   logic [OPD_PAGE_W-1:0] page;
   modport producer (input opcode, output reg_num, ri_sel, page);
   modport consumer (output opcode, input reg_num, ri_sel, page);
endinterface

// ===== core/opd_field_xtr.sv
// operand field extractor: register number, indirect select, jump page
`timescale 1ns/1ps
module opd_field_xtr
   import opd_pkg::*;
(
   opd_fld_if.producer fld
);
   // register and pointer selects come straight from the low opcode bits
   assign fld.reg_num = fld.opcode[OPD_REG_LSB +: OPD_REG_W];
   assign fld.ri_sel = fld.opcode[OPD_RI_BIT];
   // upper three bits form address bits 10:8 of 11-bit jumps and calls
   assign fld.page = fld.opcode[OPD_PAGE_LSB +: OPD_PAGE_W];
endmodule // opd_field_xtr

// ===== verification/opd_fetch_model.sv
// partner model: program fetch side that offers opcode bytes to the decoder
`timescale 1ns/1ps
module opd_fetch_model
   import opd_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // command from the bench
   input wire logic i_go,
   input wire logic [7:0] i_byte,
   // request to the decoder
   output logic o_op_valid,
   output logic [7:0] o_opcode
);
   logic [7:0] last_q;

   // no request can leave while the core is held in reset
   assign o_op_valid = i_go & i_rst_n;
   // idle byte lane shows the inverse of the last opcode, so a decoder that
   // samples it without a request is caught instead of seeing a stale match
   assign o_opcode = o_op_valid ? i_byte : ~last_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         last_q <= 8'h00;
      end else if (o_op_valid) begin
         last_q <= i_byte;
      end
   end
endmodule // opd_fetch_model

// ===== verification/tb_top.sv
// testbench: table-driven check of the upper-range opcode decoder
`timescale 1ns/1ps
`define CHK(got, exp, what) \
   begin compares++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] %0t %s", $time, what); end end
module tb_top;
   import opd_pkg::*;
   logic clk;
   logic rst_n;
   logic go;
   logic [7:0] cmd_byte;
   logic op_valid;
   logic [7:0] opcode;
   logic o_valid;
   logic o_known;
   logic [7:0] o_opcode;
   opd_class_t o_cls;
   opd_opnd_t o_opnd;
   logic [2:0] reg_num;
   logic ri;
   logic [2:0] page;
   int err_count = 0;
   int compares = 0;

   opd_fetch_model fetch_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_byte(cmd_byte),
      .o_op_valid(op_valid), .o_opcode(opcode));
   opd_dec dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_op_valid(op_valid), .i_opcode(opcode),
      .o_valid(o_valid), .o_known(o_known), .o_opcode(o_opcode), .o_op_class(o_cls),
      .o_opnd(o_opnd), .o_reg_num(reg_num), .o_ri_sel(ri), .o_page(page));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // reference classification, worked out independently per opcode row
   function automatic void exp_dec(input logic [7:0] op, output opd_class_t c,
      output opd_opnd_t o);
      logic [3:0] lo;
      logic [9:0] r;
      lo = op[3:0];
      o = lo[3] ? OPD_O_REG : (lo[3:1] == 3'h3) ? OPD_O_IND : (lo == 4'h5) ? OPD_O_DIR : OPD_O_IMM;
      c = OPD_C_NONE;
      if (lo >= 4'h4) begin
         case (op[7:4])
            4'h4: c = OPD_C_OR_A;
            4'h5: c = OPD_C_AND_A;
            4'h6: c = OPD_C_XOR_A;
            4'h7: c = OPD_C_LOAD_IMM;
            4'hc: c = OPD_C_XCH;
            4'hd: c = OPD_C_DJNZ;
            4'he: c = OPD_C_TO_A;
            4'hf: c = OPD_C_FROM_A;
            default: c = OPD_C_NONE;
         endcase
      end
      r = {c, o};
      case (op)
         8'h40: r = {OPD_C_JC, OPD_O_REL};
         8'h50: r = {OPD_C_JNC, OPD_O_REL};
         8'h60: r = {OPD_C_JZ, OPD_O_REL};
         8'h70: r = {OPD_C_JNZ, OPD_O_REL};
         8'hc0: r = {OPD_C_PUSH, OPD_O_DIR};
         8'hd0: r = {OPD_C_POP, OPD_O_DIR};
         8'he0: r = {OPD_C_XRD, OPD_O_DPTR};
         8'hf0: r = {OPD_C_XWR, OPD_O_DPTR};
         8'h42: r = {OPD_C_OR_DA, OPD_O_DIR};
         8'h43: r = {OPD_C_OR_DI, OPD_O_DIR};
         8'h52: r = {OPD_C_AND_DA, OPD_O_DIR};
         8'h53: r = {OPD_C_AND_DI, OPD_O_DIR};
         8'h62: r = {OPD_C_XOR_DA, OPD_O_DIR};
         8'h63: r = {OPD_C_XOR_DI, OPD_O_DIR};
         8'h72: r = {OPD_C_OR_CBIT, OPD_O_BIT};
         8'h73: r = {OPD_C_JMP_IND, OPD_O_DPTR};
         8'h74: r = {OPD_C_LOAD_IMM, OPD_O_ACC};
         8'hc2: r = {OPD_C_CLR_BIT, OPD_O_BIT};
         8'hc3: r = {OPD_C_CLR_C, OPD_O_CARRY};
         8'hd2: r = {OPD_C_SET_BIT, OPD_O_BIT};
         8'hd3: r = {OPD_C_SET_C, OPD_O_CARRY};
         8'hc4: r = {OPD_C_SWAP, OPD_O_ACC};
         8'hd4: r = {OPD_C_DEC_ADJ, OPD_O_ACC};
         8'he4: r = {OPD_C_CLR_A, OPD_O_ACC};
         8'hf4: r = {OPD_C_CPL_A, OPD_O_ACC};
         8'hd6, 8'hd7: r = {OPD_C_XCHD, OPD_O_IND};
         8'he2, 8'he3: r = {OPD_C_XRD, OPD_O_IND};
         8'hf2, 8'hf3: r = {OPD_C_XWR, OPD_O_IND};
         default: r = {c, o};
      endcase
      if (op[6] && lo == 4'h1) begin
         r = {(op[4] ? OPD_C_ACALL : OPD_C_AJMP), OPD_O_ADDR11};
      end
      c = opd_class_t'(r[9:4]);
      o = (c == OPD_C_NONE) ? OPD_O_NONE : opd_opnd_t'(r[3:0]);
   endfunction

   task automatic check_op(input logic [7:0] op, inout int miss);
      opd_class_t ec;
      opd_opnd_t eo;
      exp_dec(op, ec, eo);
      if ({o_valid, o_known, o_opcode, o_cls, o_opnd} !== {1'b1, op[6], op, ec, eo}) begin
         miss++;
      end
      `CHK({reg_num, ri}, {op[2:0], op[0]}, "register field")
      `CHK(page, op[7:5], "jump page field")
   endtask

   // back-to-back requests, one per cycle, then one idle cycle to see the hold
   task automatic burst(input logic [7:0] ops[$], output int miss);
      miss = 0;
      foreach (ops[i]) begin
         @(posedge clk);
         go <= 1'b1;
         cmd_byte <= ops[i];
         #1;
         if (i > 0) check_op(ops[i-1], miss);
      end
      @(posedge clk);
      go <= 1'b0;
      #1;
      check_op(ops[ops.size()-1], miss);
      @(posedge clk);
      #1;
      if (o_valid !== 1'b0 || o_opcode !== ops[ops.size()-1]) miss++;
   endtask

   task automatic t_branch();
      logic [7:0] ops[$];
      int miss;
      // open on an uncovered opcode so an unknown answer follows an idle gap
      ops = {8'h01, 8'h40, 8'h50, 8'h60, 8'h70, 8'h73, 8'h3f, 8'h80, 8'hbf};
      for (int k = 0; k < 8; k++) begin
         if (k[1]) begin
            ops.push_back({k[2:0], 5'h01});
            ops.push_back({k[2:0], 5'h11});
         end
      end
      burst(ops, miss);
      `CHK(miss, 0, "branch classes")
      $display("test branch done");
   endtask

   task automatic t_logic();
      logic [7:0] ops[$];
      int miss;
      for (int k = 8'h42; k <= 8'h6f; k++) begin
         if (k[3:1] != 3'h0) ops.push_back(k[7:0]);
      end
      burst(ops, miss);
      `CHK(miss, 0, "logic ops")
      $display("test logic done");
   endtask

   task automatic t_moves();
      logic [7:0] ops[$];
      int miss;
      for (int k = 8'h74; k <= 8'h7f; k++) ops.push_back(k[7:0]);
      for (int k = 8'he0; k <= 8'hff; k++) begin
         if (k[3:0] != 4'h1 && k[3:0] != 4'h4) ops.push_back(k[7:0]);
      end
      // end on 0x74 so its answer is also seen held through an idle cycle
      ops.push_back(8'h74);
      burst(ops, miss);
      `CHK(miss, 0, "move classes")
      $display("test moves done");
   endtask

   task automatic t_misc();
      logic [7:0] ops[$];
      int miss;
      ops = {8'h72, 8'he4, 8'hf4, 8'hc0, 8'hc2, 8'hc3, 8'hc4, 8'hd0, 8'hd2, 8'hd3, 8'hd4};
      burst(ops, miss);
      `CHK(miss, 0, "stack and bit classes")
      ops.delete();
      for (int k = 8'hc5; k <= 8'hdf; k++) begin
         if (k[3:0] > 4'h4) ops.push_back(k[7:0]);
      end
      burst(ops, miss);
      `CHK(miss, 0, "exchange classes")
      $display("test misc done");
   endtask

   // reset in mid-run clears the answer, then the first edge after release is usable
   task automatic t_reset();
      int miss;
      logic [26:0] snap;
      miss = 0;
      @(posedge clk);
      go <= 1'b1;
      cmd_byte <= 8'hff;
      @(posedge clk);
      go <= 1'b0;
      rst_n <= 1'b0;
      #1;
      snap = {o_valid, o_known, o_opcode, o_cls, o_opnd, reg_num, ri, page};
      `CHK(snap, 27'h0, "reset")
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      go <= 1'b1;
      cmd_byte <= 8'hd5;
      @(posedge clk);
      go <= 1'b0;
      #1;
      check_op(8'hd5, miss);
      `CHK(miss, 0, "first request after reset")
      $display("test reset done");
   endtask

   task automatic results();
      $display("compares=%0d mismatches=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("[ERR] %0t run did not finish", $time);
      results();
   end

   initial begin
      rst_n = 1'b0;
      go = 1'b0;
      cmd_byte = 8'h00;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_branch();
      t_logic();
      t_moves();
      t_misc();
      t_reset();
      results();
   end
endmodule // tb_top
